/* adc_cal_pkg.sv */
// Constants shared by the converter configuration and calibration register bank.
// Assumes byte-wide register access through the serial command decoder of the device.
package adc_cal_pkg;

  // Register addresses.
  localparam logic [7:0] ADDR_FILTER_CONFIG  = 8'h01;
  localparam logic [7:0] ADDR_INPUT_GAIN_CFG = 8'h02;
  localparam logic [7:0] ADDR_HP_CORNER_LOW  = 8'h03;
  localparam logic [7:0] ADDR_HP_CORNER_HIGH = 8'h04;
  localparam logic [7:0] ADDR_OFFSET_LOW     = 8'h05;
  localparam logic [7:0] ADDR_OFFSET_MID     = 8'h06;
  localparam logic [7:0] ADDR_OFFSET_HIGH    = 8'h07;
  localparam logic [7:0] ADDR_GAIN_LOW       = 8'h08;
  localparam logic [7:0] ADDR_GAIN_MID       = 8'h09;
  localparam logic [7:0] ADDR_GAIN_HIGH      = 8'h0a;

  // Reset values.
  localparam logic [7:0] RST_FILTER_CONFIG  = 8'h52;
  localparam logic [6:0] RST_INPUT_GAIN_CFG = 7'h08;
  localparam logic [7:0] RST_HP_CORNER_LOW  = 8'h32;
  localparam logic [7:0] RST_HP_CORNER_HIGH = 8'h03;
  localparam logic [7:0] RST_OFFSET_BYTE    = 8'h00;
  localparam logic [7:0] RST_GAIN_LOW       = 8'h00;
  localparam logic [7:0] RST_GAIN_MID       = 8'h00;
  localparam logic [7:0] RST_GAIN_HIGH      = 8'h40;

  // Field positions of the input and gain configuration register.
  localparam int INSEL_MSB = 6;
  localparam int INSEL_LSB = 4;
  localparam int AMP_MODULATION_ENABLE_BIT  = 3;
  localparam int GAIN_MSB  = 2;
  localparam int GAIN_LSB  = 0;

  // Field positions of the filter configuration register.
  localparam int FPATH_MSB = 1;
  localparam int FPATH_LSB = 0;

  // Input select codes.
  localparam logic [2:0] INSEL_PAIR_ONE  = 3'h0;
  localparam logic [2:0] INSEL_PAIR_TWO  = 3'h1;
  localparam logic [2:0] INSEL_SHORT     = 3'h2;
  localparam logic [2:0] INSEL_TIED      = 3'h3;
  localparam logic [2:0] INSEL_EXT_SHORT = 3'h4;

  // Highest gain code, gain of 64.
  localparam logic [2:0] GAIN_CODE_MAX = 3'h6;

  // Filter path code that bypasses the correction stage.
  localparam logic [1:0] FPATH_SINC_ONLY = 2'h1;

  // Readings discarded after a register write.
  localparam logic [5:0] DISCARD_COUNT = 6'h3f;

  // Correction arithmetic: unity gain word is two to the 22nd.
  localparam int GAIN_FRAC_BITS = 22;
  localparam logic signed [58:0] OUT_MAX = 59'sh000_0000_7fff_ffff;
  localparam logic signed [58:0] OUT_MIN = -59'sh000_0000_8000_0000;

endpackage : adc_cal_pkg

/* adc_cal_regs_props.sv */
// Concurrent checks on the ports of the register bank.
// Assumes one clock, clk, and a synchronous active-high reset, rst.
`timescale 1ns/1ps
`default_nettype none
module adc_cal_regs_props
  import adc_cal_pkg::*;
(
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst,
  // Register access.
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic [7:0]  regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic [7:0]  regRdData,
  input wire logic        regRdValid,
  // Data path.
  input wire logic        filtValid,
  input wire logic [31:0] filtData,
  input wire logic        outValid,
  input wire logic [31:0] outData,
  input wire logic        restartBusy,
  // Controls.
  input wire logic        selPairTwo,
  input wire logic [2:0]  gainAmpSetting,
  input wire logic [6:0]  gainFactor,
  input wire logic [1:0]  filterPathSelect
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  a_reserved_bit: assert property (regRdEn && regAddr == ADDR_INPUT_GAIN_CFG |=> regRdValid && !regRdData[7])
    else $error("reserved bit read back set");
  a_gain_power: assert property (gainAmpSetting <= GAIN_CODE_MAX |-> gainFactor == (7'h01 << gainAmpSetting))
    else $error("gain factor wrong");
  a_pair_two_route: assert property (regWrEn && regAddr == ADDR_INPUT_GAIN_CFG &&
    regWrData[6:4] == INSEL_PAIR_TWO |-> ##2 selPairTwo) else $error("pair two not routed");
  a_write_restart: assert property (regWrEn |=> restartBusy) else $error("write did not restart");
  a_discard_drop: assert property (filtValid && restartBusy |=> !outValid) else $error("word not discarded");
  a_out_latency: assert property (filtValid && !restartBusy && !regWrEn |=> outValid)
    else $error("result missing");
  a_out_quiet: assert property (!filtValid |=> !outValid && $stable(outData)) else $error("spurious result");
  a_sinc_bypass: assert property (filtValid ##1 filterPathSelect == FPATH_SINC_ONLY |->
    outData == $past(filtData)) else $error("bypass altered data");
endmodule : adc_cal_regs_props
bind adc_input_gain_calibration_regs adc_cal_regs_props adc_cal_regs_props_i (.clk, .rst, .regWrEn, .regRdEn,
  .regAddr, .regWrData, .regRdData, .regRdValid, .filtValid, .filtData, .outValid, .outData, .restartBusy,
  .selPairTwo, .gainAmpSetting, .gainFactor, .filterPathSelect);
`default_nettype wire

/* adc_input_gain_calibration_regs.sv */
// Configuration and calibration register bank of a delta-sigma converter with its correction stage.
// Assumes a serial command decoder delivers byte register accesses and a calibration
// sequencer delivers finished calibration words, all synchronous to clk.
//
// Function
// - Input select 000 pair one, 001 pair two, 010 short, 011 tied, 100 external short.
// - Chopping enable bit turns amplifier chopping on or off; set after reset.
// - Gain field selects amplifier gain of two to the code, codes 000 to 110.
// - High-pass corner word from low and high bytes, reset 32h and 03h.
// - Offset word assembled from three byte registers, low, mid and high bytes.
// - Offset word aligned to the top of the 32-bit result before subtraction.
// - Offset word is signed two's complement, from 7FFFFFh down to 800000h.
// - Zero offset word, its reset value, leaves data uncorrected.
// - Output equals filter output minus offset, times gain word over 400000h.
// - Gain word is unsigned with unity at 400000h.
// - Gain word resets to 400000h: high byte 40h, lower bytes zero.
// - Host writes offset and gain words; calibration completion also overwrites them.
// - Sinc-only filter path skips offset subtraction and gain scaling.
// - Filter path select code 01 chooses sinc-only output with correction bypassed.
// - Every register write restarts processing; next 63 readings are discarded.
`timescale 1ns/1ps
`default_nettype none
module adc_input_gain_calibration_regs
  import adc_cal_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Register access from the command decoder.
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  output var  logic [7:0]  regRdData,
  output var  logic        regRdValid,
  // Finished calibration results.
  input  wire logic        calOffsetDone,
  input  wire logic        calGainDone,
  input  wire logic [23:0] calWord,
  // Digital filter output.
  input  wire logic        filtValid,
  input  wire logic [31:0] filtData,
  // Corrected conversion output.
  output var  logic        outValid,
  output var  logic [31:0] outData,
  output var  logic        restartBusy,
  // Analog front end controls.
  output var  logic        selPairOne,
  output var  logic        selPairTwo,
  output var  logic        selShort,
  output var  logic        selTied,
  output var  logic        selExtShort,
  output var  logic        ampModulationEnable,
  output var  logic [2:0]  gainAmpSetting,
  output var  logic [6:0]  gainFactor,
  // Filter controls.
  output var  logic [1:0]  filterPathSelect,
  output var  logic [15:0] highpassCornerWord
);

  ////////////////////////////////////////////////////////////////////////////////////////////////

  logic [7:0]  filterConfig_r;
  logic [6:0]  inputGainConfig_r;
  logic [7:0]  hpLow_r;
  logic [7:0]  hpHigh_r;
  logic [7:0]  offLow_r;
  logic [7:0]  offMid_r;
  logic [7:0]  offHigh_r;
  logic [7:0]  gainLow_r;
  logic [7:0]  gainMid_r;
  logic [7:0]  gainHigh_r;
  logic [5:0]  discard_r;
  logic [5:0]  discard_nxt;
  logic [7:0]  rdMux;
  logic [23:0] offsetCorrectionWord;
  logic [23:0] gainCorrectionWord;
  logic        hostWr;
  logic        wrFilterCfg;
  logic        wrInputCfg;
  logic        wrHpLow;
  logic        wrHpHigh;
  logic        wrOffLow;
  logic        wrOffMid;
  logic        wrOffHigh;
  logic        wrGainLow;
  logic        wrGainMid;
  logic        wrGainHigh;
  logic [2:0]  inSelCode;
  logic [2:0]  gainCode;

  corr_if cif ();

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Write strobes; any host write, mapped or not, restarts the converter.

  assign hostWr      = regWrEn;
  assign wrFilterCfg = hostWr && regAddr == ADDR_FILTER_CONFIG;
  assign wrInputCfg  = hostWr && regAddr == ADDR_INPUT_GAIN_CFG;
  assign wrHpLow     = hostWr && regAddr == ADDR_HP_CORNER_LOW;
  assign wrHpHigh    = hostWr && regAddr == ADDR_HP_CORNER_HIGH;
  assign wrOffLow    = hostWr && regAddr == ADDR_OFFSET_LOW;
  assign wrOffMid    = hostWr && regAddr == ADDR_OFFSET_MID;
  assign wrOffHigh   = hostWr && regAddr == ADDR_OFFSET_HIGH;
  assign wrGainLow   = hostWr && regAddr == ADDR_GAIN_LOW;
  assign wrGainMid   = hostWr && regAddr == ADDR_GAIN_MID;
  assign wrGainHigh  = hostWr && regAddr == ADDR_GAIN_HIGH;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  always_ff @(posedge clk) begin
    if (rst) begin
      filterConfig_r <= RST_FILTER_CONFIG;
    end else if (wrFilterCfg) begin
      filterConfig_r <= regWrData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      inputGainConfig_r <= RST_INPUT_GAIN_CFG;
    end else if (wrInputCfg) begin
      inputGainConfig_r <= regWrData[6:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hpLow_r <= RST_HP_CORNER_LOW;
    end else if (wrHpLow) begin
      hpLow_r <= regWrData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hpHigh_r <= RST_HP_CORNER_HIGH;
    end else if (wrHpHigh) begin
      hpHigh_r <= regWrData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Offset correction bytes; a finished calibration wins over a host write.

  always_ff @(posedge clk) begin
    if (rst) begin
      offLow_r <= RST_OFFSET_BYTE;
    end else if (calOffsetDone) begin
      offLow_r <= calWord[7:0];
    end else if (wrOffLow) begin
      offLow_r <= regWrData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      offMid_r <= RST_OFFSET_BYTE;
    end else if (calOffsetDone) begin
      offMid_r <= calWord[15:8];
    end else if (wrOffMid) begin
      offMid_r <= regWrData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      offHigh_r <= RST_OFFSET_BYTE;
    end else if (calOffsetDone) begin
      offHigh_r <= calWord[23:16];
    end else if (wrOffHigh) begin
      offHigh_r <= regWrData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Gain correction bytes; a finished calibration wins over a host write.

  always_ff @(posedge clk) begin
    if (rst) begin
      gainLow_r <= RST_GAIN_LOW;
    end else if (calGainDone) begin
      gainLow_r <= calWord[7:0];
    end else if (wrGainLow) begin
      gainLow_r <= regWrData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gainMid_r <= RST_GAIN_MID;
    end else if (calGainDone) begin
      gainMid_r <= calWord[15:8];
    end else if (wrGainMid) begin
      gainMid_r <= regWrData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gainHigh_r <= RST_GAIN_HIGH;
    end else if (calGainDone) begin
      gainHigh_r <= calWord[23:16];
    end else if (wrGainHigh) begin
      gainHigh_r <= regWrData;
    end
  end

  assign offsetCorrectionWord = {offHigh_r, offMid_r, offLow_r};
  assign gainCorrectionWord   = {gainHigh_r, gainMid_r, gainLow_r};

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Register read back.

  always_comb begin
    case (regAddr)
      ADDR_FILTER_CONFIG:  rdMux = filterConfig_r;
      ADDR_INPUT_GAIN_CFG: rdMux = {1'b0, inputGainConfig_r};
      ADDR_HP_CORNER_LOW:  rdMux = hpLow_r;
      ADDR_HP_CORNER_HIGH: rdMux = hpHigh_r;
      ADDR_OFFSET_LOW:     rdMux = offLow_r;
      ADDR_OFFSET_MID:     rdMux = offMid_r;
      ADDR_OFFSET_HIGH:    rdMux = offHigh_r;
      ADDR_GAIN_LOW:       rdMux = gainLow_r;
      ADDR_GAIN_MID:       rdMux = gainMid_r;
      ADDR_GAIN_HIGH:      rdMux = gainHigh_r;
      default:             rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      regRdData  <= 8'h00;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
      if (regRdEn) begin
        regRdData <= rdMux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Front end decode.

  assign inSelCode = inputGainConfig_r[INSEL_MSB:INSEL_LSB];
  assign gainCode  = inputGainConfig_r[GAIN_MSB:GAIN_LSB];

  always_ff @(posedge clk) begin
    if (rst) begin
      selPairOne  <= RST_INPUT_GAIN_CFG[INSEL_MSB:INSEL_LSB] == INSEL_PAIR_ONE;
      selPairTwo  <= RST_INPUT_GAIN_CFG[INSEL_MSB:INSEL_LSB] == INSEL_PAIR_TWO;
      selShort    <= RST_INPUT_GAIN_CFG[INSEL_MSB:INSEL_LSB] == INSEL_SHORT;
      selTied     <= RST_INPUT_GAIN_CFG[INSEL_MSB:INSEL_LSB] == INSEL_TIED;
      selExtShort <= RST_INPUT_GAIN_CFG[INSEL_MSB:INSEL_LSB] == INSEL_EXT_SHORT;
    end else begin
      selPairOne  <= inSelCode == INSEL_PAIR_ONE;
      selPairTwo  <= inSelCode == INSEL_PAIR_TWO;
      selShort    <= inSelCode == INSEL_SHORT;
      selTied     <= inSelCode == INSEL_TIED;
      selExtShort <= inSelCode == INSEL_EXT_SHORT;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ampModulationEnable <= RST_INPUT_GAIN_CFG[AMP_MODULATION_ENABLE_BIT];
      gainAmpSetting      <= RST_INPUT_GAIN_CFG[GAIN_MSB:GAIN_LSB];
      gainFactor          <= 7'(7'h01 << RST_INPUT_GAIN_CFG[GAIN_MSB:GAIN_LSB]);
    end else begin
      ampModulationEnable <= inputGainConfig_r[AMP_MODULATION_ENABLE_BIT];
      gainAmpSetting      <= gainCode;
      if (gainCode <= GAIN_CODE_MAX) begin
        gainFactor <= 7'(7'h01 << gainCode);
      end else begin
        gainFactor <= 7'(7'h01 << GAIN_CODE_MAX);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      filterPathSelect <= RST_FILTER_CONFIG[FPATH_MSB:FPATH_LSB];
    end else begin
      filterPathSelect <= filterConfig_r[FPATH_MSB:FPATH_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      highpassCornerWord <= {RST_HP_CORNER_HIGH, RST_HP_CORNER_LOW};
    end else begin
      highpassCornerWord <= {hpHigh_r, hpLow_r};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Restart after a register write: discard the following readings.

  always_comb begin
    discard_nxt = discard_r;
    if (hostWr) begin
      discard_nxt = DISCARD_COUNT;
    end else if (filtValid && discard_r != 6'h00) begin
      discard_nxt = discard_r - 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      discard_r <= 6'h00;
    end else begin
      discard_r <= discard_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Correction stage.

  assign cif.rawData    = filtData;
  assign cif.offsetWord = offsetCorrectionWord;
  assign cif.gainWord   = gainCorrectionWord;
  assign cif.bypass     = filterConfig_r[FPATH_MSB:FPATH_LSB] == FPATH_SINC_ONLY;

  correction_engine u_engine (
    .cif (cif.engine)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      outValid    <= 1'b0;
      outData     <= 32'h0000_0000;
      restartBusy <= 1'b0;
    end else begin
      outValid    <= filtValid && !hostWr && discard_r == 6'h00;
      restartBusy <= discard_nxt != 6'h00;
      if (filtValid) begin
        outData <= cif.corrData;
      end
    end
  end

endmodule : adc_input_gain_calibration_regs
`default_nettype wire

/* corr_if.sv */
// Interface between the register bank and the offset and gain correction datapath.
// Assumes both ends run on the same clock; the datapath is purely combinational.
`timescale 1ns/1ps
`default_nettype none
interface corr_if;
  logic [31:0] rawData;
  logic [23:0] offsetWord;
  logic [23:0] gainWord;
  logic        bypass;
  logic [31:0] corrData;

  modport bank   (output rawData, output offsetWord, output gainWord, output bypass, input corrData);
  modport engine (input rawData, input offsetWord, input gainWord, input bypass, output corrData);
endinterface : corr_if
`default_nettype wire

/* correction_engine.sv */
// Offset subtraction and full-scale scaling of one filter output word.
// Assumes the caller registers the result; this module has no state.
`timescale 1ns/1ps
`default_nettype none
module correction_engine
  import adc_cal_pkg::*;
(
  // Datapath.
  corr_if.engine cif
);

  logic signed [33:0] diffWord;
  logic signed [58:0] product;
  logic signed [58:0] scaled;

  always_comb begin
    // Offset left-justified onto the 32-bit result, signed.
    diffWord = $signed({{2{cif.rawData[31]}}, cif.rawData})
             - $signed({{2{cif.offsetWord[23]}}, cif.offsetWord, 8'h00});
    product = diffWord * $signed({1'b0, cif.gainWord});
    scaled = product >>> GAIN_FRAC_BITS;
    if (cif.bypass) begin
      cif.corrData = cif.rawData;
    end else if (scaled > OUT_MAX) begin
      cif.corrData = OUT_MAX[31:0];
    end else if (scaled < OUT_MIN) begin
      cif.corrData = OUT_MIN[31:0];
    end else begin
      cif.corrData = scaled[31:0];
    end
  end

endmodule : correction_engine
`default_nettype wire

/* host_model.sv */
// Host controller that writes and reads device registers.
// Assumes it is called at a falling edge of clk.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock.
  input  wire logic       clk,
  // Register access.
  output var  logic       regWrEn,
  output var  logic       regRdEn,
  output var  logic [7:0] regAddr,
  output var  logic [7:0] regWrData,
  input  wire logic [7:0] regRdData,
  input  wire logic       regRdValid
);
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end
  ////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge clk);
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
    @(negedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    regRdEn = 1'b1;
    regAddr = a;
    @(negedge clk);
    v = regRdValid;
    d = regRdData;
    regRdEn = 1'b0;
    regAddr = ~a;
    @(negedge clk);
  endtask : rd
endmodule : host_model
`default_nettype wire

/* testbench.sv */
// Self-checking bench with a model of the registers and the correction.
// Assumes the host model drives register access; inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import adc_cal_pkg::*;
  logic        clk, rst, regWrEn, regRdEn, regRdValid, calOffsetDone, calGainDone, filtValid, outValid;
  logic        restartBusy, selPairOne, selPairTwo, selShort, selTied, selExtShort, ampModulationEnable, rdOk;
  logic [7:0]  regAddr, regWrData, regRdData, rdByte;
  logic [2:0]  gainAmpSetting;
  logic [6:0]  gainFactor;
  logic [1:0]  filterPathSelect;
  logic [15:0] highpassCornerWord;
  logic [23:0] calWord;
  logic [31:0] filtData, outData;
  logic [7:0]  regs [0:10];
  logic [23:0] offs [0:4] = '{24'h000000, 24'h7fffff, 24'h800000, 24'h000001, 24'hffffff};
  logic [23:0] gains [0:4] = '{24'h400000, 24'h800000, 24'h200000, 24'h000000, 24'hffffff};
  int          miscompares = 0;
  int          checked = 0;
  int          cycles = 0;
  adc_input_gain_calibration_regs adc_input_gain_calibration_regs_i (.clk, .rst, .regWrEn, .regRdEn, .regAddr,
    .regWrData, .regRdData, .regRdValid, .calOffsetDone, .calGainDone, .calWord, .filtValid, .filtData, .outValid,
    .outData, .restartBusy, .selPairOne, .selPairTwo, .selShort, .selTied, .selExtShort, .ampModulationEnable,
    .gainAmpSetting, .gainFactor, .filterPathSelect, .highpassCornerWord);
  host_model host_model_i (.clk, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .regRdValid);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      give_verdict();
    end
  end
  ////////////////////////////////////////
  task automatic give_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task automatic chkData(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chkData
  task automatic chkCtl(input string n, input logic [15:0] e, input logic [15:0] g);
    chkData(n, {16'h0, e}, {16'h0, g});
  endtask : chkCtl
  function automatic logic [31:0] model(input logic [31:0] d);
    longint x;
    if (regs[1][1:0] == FPATH_SINC_ONLY) return d;
    x = longint'($signed(d)) - longint'($signed({regs[7], regs[6], regs[5]})) * 256;
    x = (x * longint'({regs[10], regs[9], regs[8]})) >>> 22;
    if (x > 64'sh7fffffff) x = 64'sh7fffffff;
    if (x < -64'sh80000000) x = -64'sh80000000;
    return x[31:0];
  endfunction : model
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_model_i.wr(a, d);
    if (a >= ADDR_FILTER_CONFIG && a <= ADDR_GAIN_HIGH) regs[a] = (a == ADDR_INPUT_GAIN_CFG) ? (d & 8'h7f) : d;
  endtask : wr
  task automatic rdChk(input logic [7:0] a);
    host_model_i.rd(a, rdByte, rdOk);
    chkCtl("regRdValid", 16'h1, {15'h0, rdOk});
    chkCtl("regRdData", {8'h0, (a >= ADDR_FILTER_CONFIG && a <= ADDR_GAIN_HIGH) ? regs[a] : 8'h00},
      {8'h0, rdByte});
  endtask : rdChk
  task automatic send(input logic [31:0] d, input logic v);
    filtValid = 1'b1;
    filtData = d;
    @(negedge clk);
    chkCtl("outValid", {15'h0, v}, {15'h0, outValid});
    if (v) chkData("outData", model(d), outData);
    filtValid = 1'b0;
    filtData = ~d;
    @(negedge clk);
  endtask : send
  task automatic drain();
    repeat (63) send($urandom, 1'b0);
    chkCtl("restartBusy", 16'h0, {15'h0, restartBusy});
  endtask : drain
  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    calOffsetDone = 1'b0;
    calGainDone = 1'b0;
    calWord = 24'h0;
    filtValid = 1'b0;
    filtData = 32'h0;
    void'($urandom(32'hd0b9));
    regs = '{1: 8'h52, 2: 8'h08, 3: 8'h32, 4: 8'h03, 10: 8'h40, default: 8'h00};
    repeat (8) @(negedge clk);
    rst = 1'b0;
    for (int a = 0; a < 12; a++) rdChk(a[7:0]);
    chkCtl("highpassCornerWord", 16'h0332, highpassCornerWord);
    chkCtl("ampModulationEnable", 16'h1, {15'h0, ampModulationEnable});
    chkCtl("filterPathSelect", {14'h0, RST_FILTER_CONFIG[1:0]}, {14'h0, filterPathSelect});
    send(32'h00001000, 1'b1);
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_INPUT_GAIN_CFG, {1'b1, c[2:0], c[0], 3'(7 - c)});
      @(negedge clk);
      chkCtl("selVector", (c < 5) ? 16'h1 << c : 16'h0,
        {11'h0, selExtShort, selTied, selShort, selPairTwo, selPairOne});
      chkCtl("gainAmpSetting", {13'h0, 3'(7 - c)}, {13'h0, gainAmpSetting});
      chkCtl("ampModulationEnable", {15'h0, c[0]}, {15'h0, ampModulationEnable});
      chkCtl("gainFactor", (c == 0) ? 16'h40 : 16'h1 << (7 - c), {9'h0, gainFactor});
      rdChk(ADDR_INPUT_GAIN_CFG);
    end
    wr(ADDR_HP_CORNER_LOW, 8'($urandom));
    wr(ADDR_HP_CORNER_HIGH, 8'($urandom));
    @(negedge clk);
    chkCtl("highpassCornerWord", {regs[4], regs[3]}, highpassCornerWord);
    for (int k = 0; k < 5; k++) begin
      for (int b = 0; b < 3; b++) wr(ADDR_OFFSET_LOW + 8'(b), offs[k][8*b +: 8]);
      for (int b = 0; b < 3; b++) wr(ADDR_GAIN_LOW + 8'(b), gains[k][8*b +: 8]);
      drain();
      for (int b = 5; b < 11; b++) rdChk(8'(b));
      send(32'h7fffffff, 1'b1);
      send(32'h80000000, 1'b1);
      repeat (4) send($urandom, 1'b1);
    end
    calWord = 24'($urandom);
    calOffsetDone = 1'b1;
    @(negedge clk);
    calOffsetDone = 1'b0;
    {regs[7], regs[6], regs[5]} = calWord;
    calWord = 24'($urandom);
    calGainDone = 1'b1;
    @(negedge clk);
    calGainDone = 1'b0;
    {regs[10], regs[9], regs[8]} = calWord;
    for (int b = 5; b < 11; b++) rdChk(8'(b));
    send($urandom, 1'b1);
    wr(8'h0c, 8'($urandom));
    drain();
    rdChk(8'h0c);
    wr(ADDR_FILTER_CONFIG, 8'h51);
    drain();
    chkCtl("filterPathSelect", {14'h0, FPATH_SINC_ONLY}, {14'h0, filterPathSelect});
    repeat (4) send($urandom, 1'b1);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
